/* File: shared/rdtr_pkg.sv */
// Constants, register map and arithmetic helpers for the remote diode readout
package rdtr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_R1_VALUE = 8'h25;
   localparam logic [7:0] IDX_R2_VALUE = 8'h27;
   localparam logic [7:0] IDX_R1_OFS   = 8'h70;
   localparam logic [7:0] IDX_R2_OFS   = 8'h72;
   localparam logic [7:0] IDX_FRAC     = 8'h77;

   // Reset values
   localparam logic [7:0] OFS_RESET   = 8'h00;
   localparam logic [9:0] VALUE_RESET = 10'h000;

   // Fraction field positions in the fraction register
   localparam int FRAC_R1_LSB    = 2;
   localparam int FRAC_LOCAL_LSB = 4;
   localparam int FRAC_R2_LSB    = 6;

   // Averaging
   localparam int AVG_COUNT = 16;
   localparam int AVG_SHIFT = 4;
   localparam int CNT_W     = 5;

   // Sensor current levels
   localparam logic [1:0] CUR_BASE = 2'h0;
   localparam logic [1:0] CUR_N1   = 2'h1;
   localparam logic [1:0] CUR_N2   = 2'h2;

   // Chopping of the sensor current
   localparam int CLK_PERIOD_NS = 10;
   localparam int CHOP_HALF_NS  = 10000;
   localparam int CHOP_CYCLES   = (CHOP_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic {
      RDTR_CH_ONE,
      RDTR_CH_TWO
   } rdtr_chan_t;

   // Clamp a wide signed quantity into the 10-bit result range
   function automatic logic signed [9:0] sat10(input logic signed [15:0] v);
      if (v > 16'sd511) begin
         sat10 = 10'sh1FF;
      end else if (v < -16'sd512) begin
         sat10 = 10'sh200;
      end else begin
         sat10 = v[9:0];
      end
   endfunction

endpackage

/* File: shared/rdtr_meas_if.sv */
// Measurement link between the sequencer/averager and the register core
`timescale 1ns/1ps
interface rdtr_meas_if;
   logic [1:0]        cur_sel;
   logic              chan;
   logic signed [9:0] adc_data;
   logic              adc_ready;
   logic signed [9:0] result;
   logic              result_chan;
   logic              result_valid;

   modport seq  (output cur_sel, output chan, input adc_data, input adc_ready,
                 output result, output result_chan, output result_valid);
   modport core (input cur_sel, input chan, output adc_data, output adc_ready,
                 input result, input result_chan, input result_valid);
endinterface

/* File: src/rdtr_seq.sv */
// Two-step current-ratio sequencer and 16-cycle averager
`timescale 1ns/1ps
module rdtr_seq #(
   parameter int CHOP_CYCLES = rdtr_pkg::CHOP_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   rdtr_meas_if.seq  meas
);

   // Chop timer is 16 bits wide
   if (CHOP_CYCLES < 1 || CHOP_CYCLES > 65535) begin
      $error("CHOP_CYCLES out of range");
   end

   typedef enum logic { RDTR_STEP_ONE, RDTR_STEP_TWO } rdtr_step_t;

   function automatic logic signed [11:0] combine(input logic signed [9:0] d1, input logic signed [9:0] d2);
      // Twice the first step minus the second cancels a linear series term
      combine = {d1[9], d1, 1'b0} - {{2{d2[9]}}, d2};
   endfunction

   rdtr_step_t               step_reg;
   logic [15:0]              chop_reg;
   logic [1:0]               cur_reg;
   logic                     chan_reg;
   logic signed [9:0]        dv1_reg;
   logic signed [15:0]       acc_reg;
   logic [rdtr_pkg::CNT_W-1:0] cnt_reg;
   logic signed [9:0]        result_reg;
   logic                     result_chan_reg;
   logic                     valid_reg;

   wire                      chop_tick = (chop_reg == 16'h0000);
   wire signed [11:0]        sample    = combine(dv1_reg, meas.adc_data);
   wire signed [15:0]        acc_next  = acc_reg + {{4{sample[11]}}, sample};
   wire                      last_one  = (cnt_reg == 5'(rdtr_pkg::AVG_COUNT - 1));
   wire signed [15:0]        avg       = acc_next >>> rdtr_pkg::AVG_SHIFT;
   wire [1:0]                hi_level  = (step_reg == RDTR_STEP_ONE) ? rdtr_pkg::CUR_N1 : rdtr_pkg::CUR_N2;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         chop_reg <= 16'h0000;
         cur_reg  <= rdtr_pkg::CUR_BASE;
      end else if (chop_tick) begin
         chop_reg <= 16'(CHOP_CYCLES - 1);
         cur_reg  <= (cur_reg == rdtr_pkg::CUR_BASE) ? hi_level : rdtr_pkg::CUR_BASE;
      end else begin
         chop_reg <= chop_reg - 16'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         step_reg        <= RDTR_STEP_ONE;
         chan_reg        <= 1'b0;
         dv1_reg         <= 10'sh000;
         acc_reg         <= 16'sh0000;
         cnt_reg         <= '0;
         result_reg      <= 10'sh000;
         result_chan_reg <= 1'b0;
         valid_reg       <= 1'b0;
      end else begin
         valid_reg <= 1'b0;
         if (meas.adc_ready && step_reg == RDTR_STEP_ONE) begin
            dv1_reg  <= meas.adc_data;
            step_reg <= RDTR_STEP_TWO;
         end else if (meas.adc_ready) begin
            step_reg <= RDTR_STEP_ONE;
            if (last_one) begin
               // Averaged result leaves in one piece; accumulator restarts for next channel
               result_reg      <= rdtr_pkg::sat10(avg);
               result_chan_reg <= chan_reg;
               valid_reg       <= 1'b1;
               acc_reg         <= 16'sh0000;
               cnt_reg         <= '0;
               chan_reg        <= ~chan_reg;
            end else begin
               acc_reg <= acc_next;
               cnt_reg <= cnt_reg + 5'h01;
            end
         end
      end
   end

   assign meas.cur_sel      = cur_reg;
   assign meas.chan         = chan_reg;
   assign meas.result       = result_reg;
   assign meas.result_chan  = result_chan_reg;
   assign meas.result_valid = valid_reg;

endmodule

/* File: src/rdtr_top.sv */
// Remote diode temperature readout: APB registers, offset correction, freeze
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Each measurement chops base/first multiple, then base/second multiple, combines both.
// - Reported value is the average of 16 consecutive measurement cycles.
// - Result held as 10-bit twos complement, split value and fraction registers.
// - Two lowest bits of each channel go to the shared fraction register.
// - Writable offset registers for remote one and remote two.
// - Offset is 8-bit twos complement, added to each averaged result before storing.
// - One offset step is half a degree, spanning plus or minus 64 degrees.
// - Fraction bits 3:2 remote one, 5:4 local, 7:6 remote two.
// - Reading the fraction register freezes values until each value is read.
// - Both offset registers reset to zero.
module rdtr_top #(
   parameter int CHOP_CYCLES = rdtr_pkg::CHOP_CYCLES
) (
   // Clock and reset
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RST_B_IN,
   // APB slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // Analog front end
   input  wire logic [9:0]  ADC_DATA_IN,
   input  wire logic        ADC_READY_IN,
   output logic      [1:0]  CURRENT_SEL_OUT,
   output logic             CHANNEL_SEL_OUT,
   // Status
   output logic             VALUES_FROZEN_OUT
);

   // Chop timer in the sequencer is 16 bits wide
   if (CHOP_CYCLES < 1 || CHOP_CYCLES > 65535) begin
      $error("CHOP_CYCLES out of range");
   end

   rdtr_meas_if meas ();

   rdtr_seq #(
      .CHOP_CYCLES (CHOP_CYCLES)
   ) u_seq (
      .clk_in   (SYS_CLK_IN),
      .rst_b_in (RST_B_IN),
      .meas     (meas)
   );

   // Front-end inputs come from another domain: two flops each, plus a third on ready for edge detection
   logic [9:0] adc_data_s1_reg;
   logic [9:0] adc_data_s2_reg;
   logic       adc_rdy_s1_reg;
   logic       adc_rdy_s2_reg;
   logic       adc_rdy_s3_reg;

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         adc_data_s1_reg <= 10'h000;
         adc_data_s2_reg <= 10'h000;
         adc_rdy_s1_reg  <= 1'b0;
         adc_rdy_s2_reg  <= 1'b0;
         adc_rdy_s3_reg  <= 1'b0;
      end else begin
         adc_data_s1_reg <= ADC_DATA_IN;
         adc_data_s2_reg <= adc_data_s1_reg;
         adc_rdy_s1_reg  <= ADC_READY_IN;
         adc_rdy_s2_reg  <= adc_rdy_s1_reg;
         adc_rdy_s3_reg  <= adc_rdy_s2_reg;
      end
   end

   // Data must be settled before the ready edge arrives
   assign meas.adc_data  = adc_data_s2_reg;
   assign meas.adc_ready = adc_rdy_s2_reg & ~adc_rdy_s3_reg;

   // APB decode
   wire       apb_access = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
   wire       word_align = (PADDR_IN[1:0] == 2'h0);
   wire [9:0] reg_index  = PADDR_IN[11:2];
   wire       hit_r1_val = word_align & (reg_index == {2'h0, rdtr_pkg::IDX_R1_VALUE});
   wire       hit_r2_val = word_align & (reg_index == {2'h0, rdtr_pkg::IDX_R2_VALUE});
   wire       hit_r1_ofs = word_align & (reg_index == {2'h0, rdtr_pkg::IDX_R1_OFS});
   wire       hit_r2_ofs = word_align & (reg_index == {2'h0, rdtr_pkg::IDX_R2_OFS});
   wire       hit_frac   = word_align & (reg_index == {2'h0, rdtr_pkg::IDX_FRAC});
   wire       hit_any    = hit_r1_val | hit_r2_val | hit_r1_ofs | hit_r2_ofs | hit_frac;
   wire       wr_r1_ofs  = apb_access & PWRITE_IN & hit_r1_ofs;
   wire       wr_r2_ofs  = apb_access & PWRITE_IN & hit_r2_ofs;
   wire       rd_r1_val  = apb_access & ~PWRITE_IN & hit_r1_val;
   wire       rd_r2_val  = apb_access & ~PWRITE_IN & hit_r2_val;
   wire       rd_frac    = apb_access & ~PWRITE_IN & hit_frac;

   // Calibration offsets
   logic [7:0] ofs_r1_reg;
   logic [7:0] ofs_r2_reg;

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         ofs_r1_reg <= rdtr_pkg::OFS_RESET;
         ofs_r2_reg <= rdtr_pkg::OFS_RESET;
      end else begin
         if (wr_r1_ofs) begin
            ofs_r1_reg <= PWDATA_IN[7:0];
         end
         if (wr_r2_ofs) begin
            ofs_r2_reg <= PWDATA_IN[7:0];
         end
      end
   end

   // Offset correction: one offset step is two quarter-degree result steps
   wire [7:0]         ofs_sel   = meas.result_chan ? ofs_r2_reg : ofs_r1_reg;
   wire signed [15:0] ofs_ext   = {{7{ofs_sel[7]}}, ofs_sel, 1'b0};
   wire signed [15:0] res_ext   = {{6{meas.result[9]}}, meas.result};
   wire signed [9:0]  corrected = rdtr_pkg::sat10(res_ext + ofs_ext);

   // Latest completed result per channel, waiting to be published
   logic [9:0] latest_reg [2];
   logic [1:0] latest_new_reg;
   logic [9:0] vis_reg    [2];
   logic       frozen_reg;
   logic [1:0] unread_reg;

   wire        publish    = ~frozen_reg;
   wire [1:0]  unread_nxt = unread_reg & ~{rd_r2_val, rd_r1_val};

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         latest_reg[0]  <= rdtr_pkg::VALUE_RESET;
         latest_reg[1]  <= rdtr_pkg::VALUE_RESET;
         latest_new_reg <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (meas.result_valid && meas.result_chan == 1'(i)) begin
               latest_reg[i]     <= corrected;
               latest_new_reg[i] <= 1'b1; // New result wins over a publish in this cycle
            end else if (publish) begin
               latest_new_reg[i] <= 1'b0;
            end
         end
      end
   end

   // Value and fraction of a channel move together from one complete result
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         vis_reg[0] <= rdtr_pkg::VALUE_RESET;
         vis_reg[1] <= rdtr_pkg::VALUE_RESET;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (publish && latest_new_reg[i]) begin
               vis_reg[i] <= latest_reg[i];
            end
         end
      end
   end

   // Freeze from a fraction read until both value registers have been read
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         frozen_reg <= 1'b0;
         unread_reg <= 2'h0;
      end else if (rd_frac) begin
         frozen_reg <= 1'b1;
         unread_reg <= 2'h3;
      end else if (frozen_reg) begin
         unread_reg <= unread_nxt;
         frozen_reg <= (unread_nxt != 2'h0);
      end
   end

   // Read data; the local sensor is absent so its fraction reads zero
   wire [7:0] frac_byte = {vis_reg[1][1:0], 2'h0, vis_reg[0][1:0], 2'h0};
   wire [7:0] rd_byte   = hit_r1_val ? vis_reg[0][9:2] :
                          hit_r2_val ? vis_reg[1][9:2] :
                          hit_r1_ofs ? ofs_r1_reg :
                          hit_r2_ofs ? ofs_r2_reg :
                          hit_frac   ? frac_byte : 8'h00;

   // One wait state on every access; unmapped addresses answer with an error
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
      end else begin
         PREADY_OUT  <= apb_access;
         PSLVERR_OUT <= apb_access & ~hit_any;
         if (apb_access && !PWRITE_IN) begin
            PRDATA_OUT <= {24'h00_0000, rd_byte};
         end else begin
            PRDATA_OUT <= 32'h0000_0000;
         end
      end
   end

   // Front-end controls and status
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         CURRENT_SEL_OUT   <= rdtr_pkg::CUR_BASE;
         CHANNEL_SEL_OUT   <= 1'b0;
         VALUES_FROZEN_OUT <= 1'b0;
      end else begin
         CURRENT_SEL_OUT   <= meas.cur_sel;
         CHANNEL_SEL_OUT   <= meas.chan;
         VALUES_FROZEN_OUT <= frozen_reg;
      end
   end

endmodule

/* File: verification/rdtr_checker_monitor.sv */
// Port-level checker for the remote diode readout
`timescale 1ns/1ps
module rdtr_checker #(
   parameter int CHOP_CYCLES = rdtr_pkg::CHOP_CYCLES
) (
   // Clock and reset
   input wire logic        SYS_CLK_IN,
   input wire logic        RST_B_IN,
   // APB slave
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PREADY_OUT,
   input wire logic        PSLVERR_OUT,
   // Front end and status
   input wire logic [9:0]  ADC_DATA_IN,
   input wire logic        ADC_READY_IN,
   input wire logic [1:0]  CURRENT_SEL_OUT,
   input wire logic        CHANNEL_SEL_OUT,
   input wire logic        VALUES_FROZEN_OUT
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   wire take     = PSEL_IN && PENABLE_IN && !PREADY_OUT;
   wire mapped   = PADDR_IN inside {12'h094, 12'h09C, 12'h1C0, 12'h1C8, 12'h1DC};
   wire rd_frac  = take && !PWRITE_IN && PADDR_IN == 12'h1DC;
   wire rd_value = take && !PWRITE_IN && PADDR_IN inside {12'h094, 12'h09C};
   wire at_base  = CURRENT_SEL_OUT == rdtr_pkg::CUR_BASE;
   // Cycles since the current level last changed; zero until the first change
   int unsigned dwell_cnt;
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         dwell_cnt <= 0;
      end else if ($changed(CURRENT_SEL_OUT)) begin
         dwell_cnt <= 1;
      end else if (dwell_cnt != 0) begin
         dwell_cnt <= dwell_cnt + 1;
      end
   end
   AST_CHOP_DWELL: assert property ($changed(CURRENT_SEL_OUT) && dwell_cnt != 0 |-> dwell_cnt == CHOP_CYCLES)
      else $error("Current level held for the wrong number of cycles");
   AST_CUR_LEGAL: assert property (CURRENT_SEL_OUT != 2'h3)
      else $error("Illegal current code");
   // A multiple may only be left towards the base level
   AST_CHOP_VIA_BASE: assert property (!at_base |=> at_base || $stable(CURRENT_SEL_OUT))
      else $error("Current jumped between multiples");
   AST_READY_AFTER_TAKE: assert property (take |=> PREADY_OUT)
      else $error("No ready after access");
   AST_READY_PULSE: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("Ready held too long");
   AST_ERR_UNMAPPED: assert property (take |=> PSLVERR_OUT != $past(mapped))
      else $error("Error flag does not match address");
   AST_ERR_NO_DATA: assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0000_0000)
      else $error("Refused access returned data");
   AST_UPPER_ZERO: assert property (PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h00_0000)
      else $error("Upper read data not zero");
   AST_FRAC_UNUSED: assert property (rd_frac |=> PRDATA_OUT[5:4] == 2'h0 && PRDATA_OUT[1:0] == 2'h0)
      else $error("Unused fraction bits set");
   AST_FREEZE_SET: assert property (rd_frac |-> ##[1:3] VALUES_FROZEN_OUT)
      else $error("Fraction read did not freeze");
   AST_FREEZE_HOLD: assert property ($fell(VALUES_FROZEN_OUT) |-> $past(rd_value, 2) || $past(rd_value, 3))
      else $error("Freeze left without a value read");
endmodule

bind rdtr_top rdtr_checker #(.CHOP_CYCLES(CHOP_CYCLES)) i_checker (.*);

/* File: verification/rdtr_diode_model.sv */
// Behavioural remote diode and converter returning delta-VBE codes
`timescale 1ns/1ps
module rdtr_diode_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   // Drive from the readout
   input  wire logic [1:0] current_sel_in,
   input  wire logic       channel_sel_in,
   // Conversion results
   output logic      [9:0] adc_data_out,
   output logic            adc_ready_out
);
   logic [4:0] phase_reg;
   logic [1:0] multiple_reg;
   logic [3:0] ripple_reg;
   // Ripple sums to a known bias only over a full 16-sample window
   wire  [9:0] dv_first  = (channel_sel_in ? 10'h096 : 10'h00A) + {6'h00, ripple_reg};
   wire  [9:0] dv_second = channel_sel_in ? 10'h062 : 10'h028;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase_reg     <= 5'h00;
         multiple_reg  <= rdtr_pkg::CUR_N1;
         ripple_reg    <= 4'h0;
         adc_data_out  <= 10'h155;
         adc_ready_out <= 1'b0;
      end else begin
         phase_reg <= (phase_reg == 5'h17) ? 5'h00 : phase_reg + 5'h01;
         if (current_sel_in != rdtr_pkg::CUR_BASE) begin
            multiple_reg <= current_sel_in;
         end
         if (phase_reg == 5'h13) begin
            adc_data_out <= (multiple_reg == rdtr_pkg::CUR_N1) ? dv_first : dv_second;
         end
         if (phase_reg == 5'h14) begin
            adc_ready_out <= 1'b1;
            ripple_reg    <= ripple_reg + ((multiple_reg == rdtr_pkg::CUR_N1) ? 4'h1 : 4'h0);
         end
         // Code is not held once the conversion edge is gone
         if (phase_reg == 5'h00) begin
            adc_ready_out <= 1'b0;
            adc_data_out  <= ~adc_data_out;
         end
      end
   end
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the remote diode readout
`timescale 1ns/1ps
module tb;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, adc_ready, chan_sel, frozen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0]  adc_data;
   logic [1:0]  cur_sel;
   int          num_errors = 0;
   int          compares = 0;

   rdtr_top #(.CHOP_CYCLES(4)) i_dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ADC_DATA_IN(adc_data),
      .ADC_READY_IN(adc_ready), .CURRENT_SEL_OUT(cur_sel), .CHANNEL_SEL_OUT(chan_sel),
      .VALUES_FROZEN_OUT(frozen));
   rdtr_diode_model i_diode (.clk_in(clk), .rst_b_in(rst_b), .current_sel_in(cur_sel),
      .channel_sel_in(chan_sel), .adc_data_out(adc_data), .adc_ready_out(adc_ready));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [32:0] resp);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees ready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      resp = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic e);
      logic [32:0] resp;
      apb(1'b0, a, 32'h0000_0000, resp);
      chk(resp, {e, 24'h00_0000, d});
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [32:0] resp;
      apb(1'b1, a, d, resp);
      chk({32'h0000_0000, resp[32]}, 33'h0_0000_0000);
   endtask

   task automatic t_reset();
      rd(12'h1C0, 8'h00, 1'b0);
      rd(12'h1C8, 8'h00, 1'b0);
      rd(12'h070, 8'h00, 1'b1);
      rd(12'h1C2, 8'h00, 1'b1);
      wr(12'h1DC, 32'h0000_00FF);
      rd(12'h1DC, 8'h00, 1'b0);
      rd(12'h094, 8'h00, 1'b0);
      rd(12'h09C, 8'h00, 1'b0);
   endtask

   task automatic t_offset();
      // Each remote channel's offset goes in as its own signed byte
      wr(12'h1C0, 32'hFFFF_FFF9);
      wr(12'h1C8, 32'h0000_0005);
      rd(12'h1C0, 8'hF9, 1'b0);
      rd(12'h1C8, 8'h05, 1'b0);
   endtask

   task automatic t_result();
      repeat (3200) @(posedge clk);
      rd(12'h1DC, 8'hC4, 1'b0);
      repeat (3) @(posedge clk);
      chk({32'h0000_0000, frozen}, 33'h0_0000_0001);
      rd(12'h094, 8'hFB, 1'b0);
      rd(12'h09C, 8'h38, 1'b0);
      repeat (3) @(posedge clk);
      chk({32'h0000_0000, frozen}, 33'h0_0000_0000);
   endtask

   task automatic t_freeze();
      rd(12'h1DC, 8'hC4, 1'b0);
      wr(12'h1C0, 32'h0000_0000);
      repeat (3200) @(posedge clk);
      rd(12'h1DC, 8'hC4, 1'b0);
      rd(12'h094, 8'hFB, 1'b0);
      rd(12'h09C, 8'h38, 1'b0);
      repeat (4) @(posedge clk);
      rd(12'h1DC, 8'hCC, 1'b0);
      rd(12'h094, 8'hFE, 1'b0);
      rd(12'h09C, 8'h38, 1'b0);
   endtask

   // Reset in mid-run must clear written offsets and published values
   task automatic t_midreset();
      wr(12'h1C8, 32'h0000_0033);
      rd(12'h1C8, 8'h33, 1'b0);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rd(12'h1C8, 8'h00, 1'b0);
      rd(12'h1C0, 8'h00, 1'b0);
      rd(12'h094, 8'h00, 1'b0);
      rd(12'h1DC, 8'h00, 1'b0);
      rd(12'h09C, 8'h00, 1'b0);
   endtask

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_offset();
      t_result();
      t_freeze();
      t_midreset();
      end_of_test();
   end

   // Whole sequence needs under 7000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule
